// ===== pkg/umpo_consts.svh
`ifndef UMPO_CONSTS_SVH
`define UMPO_CONSTS_SVH

// Register offsets
`define UMPO_A_MODE   4'h0
`define UMPO_A_FLOW   4'h1
`define UMPO_A_OPT    4'h2
`define UMPO_A_DIV    4'h3
`define UMPO_A_TXBUF  4'h4
`define UMPO_A_RXBUF  4'h5
`define UMPO_A_STAT   4'h6
`define UMPO_A_PDIR   4'h7
`define UMPO_A_PDAT   4'h8

// Mode register bits
`define UMPO_B_CKSEL  3
`define UMPO_B_SLEEP  7
// Flow register bits
`define UMPO_B_FSEL   2
`define UMPO_B_FDIS   4
`define UMPO_B_ODRN   5
// Option register bits
`define UMPO_B_TXEN   0
`define UMPO_B_RXEN   2
`define UMPO_B_PREV   5
`define UMPO_B_DINV   6
// Port direction and data bits
`define UMPO_B_PSIN   0
`define UMPO_B_PBCLK  1
`define UMPO_B_PFLOW  2
// Status bits
`define UMPO_B_TXBSY  0
`define UMPO_B_TXBE   1
`define UMPO_B_RXFUL  2
`define UMPO_B_BCOL   3
`define UMPO_B_SINL   4
`define UMPO_B_BCLKL  5
`define UMPO_B_FLOWL  6

// Channel code with polarity, inversion and collision options
`define UMPO_CH2      2'h2

// Oversampling and frame counts
`define UMPO_OVS_LAST 4'hF
`define UMPO_OVS_MID  4'h7
`define UMPO_BIT_LAST 3'h7

`endif

// ===== pkg/umpo_pkg.sv
package umpo_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} umpo_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} umpo_rx_e;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] flow;
    logic [7:0] opt;
    logic [7:0] div;
    logic [7:0] pdir;
    logic [7:0] pdat;
    logic [7:0] txbuf;
    logic       tx_full;
    umpo_tx_e   tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic       tx_low;
    umpo_rx_e   rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bit;
    logic [7:0] rx_buf;
    logic       rx_full;
    logic       bc_flag;
    logic       bc_req;
    logic       rx_req;
    logic [7:0] rd_data;
    logic       sout;
    logic       sout_oe;
    logic       bclk_o;
    logic       bclk_oe;
    logic       flow_o;
    logic       flow_oe;
  } umpo_state_s;

  typedef struct packed {
    logic       ext_q;
    logic [7:0] cnt;
    logic       tick;
  } umpo_bg_s;

endpackage

// ===== rtl/umpo_bitgen.sv
`timescale 1ns/1ps
`include "umpo_consts.svh"

module umpo_bitgen (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       ext_sel,
  input  wire logic       ext_level,
  input  wire logic [7:0] div,
  output logic            tick
);
  import umpo_pkg::*;

  umpo_bg_s bg_ff;
  umpo_bg_s nxt_bg;
  logic     src;

  // One count per cycle, or per rising edge of the external clock
  assign src = ext_sel ? (ext_level & ~bg_ff.ext_q) : 1'b1;

  always_comb begin
    nxt_bg       = bg_ff;
    nxt_bg.ext_q = ext_level;
    nxt_bg.tick  = 1'b0;
    if (src) begin
      // Reload also when a smaller divider was just written
      if (bg_ff.cnt >= div) begin
        nxt_bg.cnt  = 8'h00;
        nxt_bg.tick = 1'b1;
      end else begin
        nxt_bg.cnt = bg_ff.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bg_ff <= '0;
    end else begin
      bg_ff <= nxt_bg;
    end
  end

  assign tick = bg_ff.tick;

  property p_int_spacing;
    @(posedge ref_clk) disable iff (sys_rst)
    (tick && !ext_sel && div != 8'h00) |=> (div == 8'h00 || !tick);
  endproperty
  a_int_spacing: assert property (p_int_spacing) else $error("internal tick too close");

  property p_ext_edge;
    @(posedge ref_clk) disable iff (sys_rst)
    (ext_sel && $past(ext_sel) && tick) |-> $past(src);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external tick without clock edge");

endmodule

// ===== rtl/umpo_top.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "umpo_consts.svh"

// Function
// - Clock select 0 frees bit-clock pin to port use; internal clock drives channel.
// - Channels 0/1, clock select 1, direction cleared: bit-clock pin is transfer clock.
// - Flow enabled, select 0, direction input: flow pin is active-low clear-to-send.
// - Flow enabled, select 1: flow pin drives active-low request-to-send.
// - Flow disabled: no handshake, flow pin is a general port.
// - Channels 0/1 with sleep bit set: receiver listens only to addressed characters.
// - In sleep, accept only characters whose top data bit is one.
// - Channel 2 inversion flips data on transmit-buffer write and receive-buffer read.
// - Channel 2 polarity reverse flips every line bit on serial-out and serial-in.
// - Channel 2 collision check samples driven and received line levels each bit.
// - Differing sampled levels raise a collision request.
// - Serial-out drives high from enable until transfer; floats if open-drain.
// - Inversion touches character bits only; start and stop keep levels.
module umpo_top #(
  parameter logic [1:0] CHANNEL = 2'h0
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            serial_out_pin_o,
  output logic            serial_out_pin_oe,
  input  wire logic       serial_in_pin_i,
  input  wire logic       bit_clock_pin_i,
  output logic            bit_clock_pin_o,
  output logic            bit_clock_pin_oe,
  input  wire logic       flow_control_pin_i,
  output logic            flow_control_pin_o,
  output logic            flow_control_pin_oe,
  output logic            rx_req,
  output logic            bc_req
);
  import umpo_pkg::*;

  umpo_state_s st_ff;
  umpo_state_s nxt_st;

  logic       is_ch2;
  logic       ext_ok;
  logic       ext_sel;
  logic       tick;
  logic       tx_en;
  logic       rx_en;
  logic       open_drain;
  logic       prev_on;
  logic       dinv_on;
  logic       sleep_on;
  logic       cts_on;
  logic       cts_ok;
  logic       rts_ready;
  logic       rx_line;
  logic       tx_busy;
  logic       bc_sample;
  logic       bc_diff;
  logic       sout_lvl;
  logic [7:0] stat_v;

  assign is_ch2     = (CHANNEL == `UMPO_CH2);
  assign ext_ok     = ~is_ch2;
  assign tx_en      = st_ff.opt[`UMPO_B_TXEN];
  assign rx_en      = st_ff.opt[`UMPO_B_RXEN];
  assign open_drain = st_ff.flow[`UMPO_B_ODRN];
  assign prev_on    = is_ch2 & st_ff.opt[`UMPO_B_PREV];
  assign dinv_on    = is_ch2 & st_ff.opt[`UMPO_B_DINV];
  assign sleep_on   = ~is_ch2 & st_ff.mode[`UMPO_B_SLEEP];
  assign tx_busy    = (st_ff.tx_st != TX_IDLE);

  // External bit clock only on channels 0/1 with the pin as input
  assign ext_sel = ext_ok & st_ff.mode[`UMPO_B_CKSEL] & ~st_ff.pdir[`UMPO_B_PBCLK];

  // Clear-to-send gating
  assign cts_on = ~st_ff.flow[`UMPO_B_FDIS] & ~st_ff.flow[`UMPO_B_FSEL]
                & ~st_ff.pdir[`UMPO_B_PFLOW];
  assign cts_ok = ~cts_on | ~flow_control_pin_i;

  // Request-to-send asserted while receiver can take a character
  assign rts_ready = rx_en & ~st_ff.rx_full;

  // Line levels after optional polarity reversal
  assign rx_line  = prev_on ? ~serial_in_pin_i : serial_in_pin_i;
  assign sout_lvl = prev_on ? st_ff.tx_low : ~st_ff.tx_low;

  // Collision sample once per transmitted bit
  assign bc_sample = is_ch2 & tick & tx_busy & (st_ff.tx_ovs == `UMPO_OVS_MID);
  assign bc_diff   = st_ff.sout ^ serial_in_pin_i;

  always_comb begin
    stat_v                 = 8'h00;
    stat_v[`UMPO_B_TXBSY]  = tx_busy;
    stat_v[`UMPO_B_TXBE]   = ~st_ff.tx_full;
    stat_v[`UMPO_B_RXFUL]  = st_ff.rx_full;
    stat_v[`UMPO_B_BCOL]   = st_ff.bc_flag;
    stat_v[`UMPO_B_SINL]   = serial_in_pin_i;
    stat_v[`UMPO_B_BCLKL]  = bit_clock_pin_i;
    stat_v[`UMPO_B_FLOWL]  = flow_control_pin_i;
  end

  umpo_bitgen u_bitgen (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .ext_sel   (ext_sel),
    .ext_level (bit_clock_pin_i),
    .div       (st_ff.div),
    .tick      (tick)
  );

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rx_req  = 1'b0;
    nxt_st.bc_req  = 1'b0;
    nxt_st.rd_data = 8'h00;

    // Transmitter
    case (st_ff.tx_st)
      TX_IDLE: begin
        if (tx_en && st_ff.tx_full && cts_ok) begin
          nxt_st.tx_sh   = st_ff.txbuf;
          nxt_st.tx_full = 1'b0;
          nxt_st.tx_ovs  = 4'h0;
          nxt_st.tx_low  = 1'b1;
          nxt_st.tx_st   = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          nxt_st.tx_ovs = st_ff.tx_ovs + 4'h1;
          if (st_ff.tx_ovs == `UMPO_OVS_LAST) begin
            nxt_st.tx_bit = 3'h0;
            nxt_st.tx_low = ~st_ff.tx_sh[0];
            nxt_st.tx_st  = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          nxt_st.tx_ovs = st_ff.tx_ovs + 4'h1;
          if (st_ff.tx_ovs == `UMPO_OVS_LAST) begin
            if (st_ff.tx_bit == `UMPO_BIT_LAST) begin
              nxt_st.tx_low = 1'b0;
              nxt_st.tx_st  = TX_STOP;
            end else begin
              nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
              nxt_st.tx_low = ~st_ff.tx_sh[1];
              nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          nxt_st.tx_ovs = st_ff.tx_ovs + 4'h1;
          if (st_ff.tx_ovs == `UMPO_OVS_LAST) begin
            nxt_st.tx_st = TX_IDLE;
          end
        end
      end
      default: begin
        nxt_st.tx_st = TX_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `UMPO_A_MODE) begin
        nxt_st.mode = reg_wdata;
      end else if (reg_addr == `UMPO_A_FLOW) begin
        nxt_st.flow = reg_wdata;
      end else if (reg_addr == `UMPO_A_OPT) begin
        nxt_st.opt = reg_wdata;
      end else if (reg_addr == `UMPO_A_DIV) begin
        nxt_st.div = reg_wdata;
      end else if (reg_addr == `UMPO_A_TXBUF) begin
        nxt_st.txbuf   = dinv_on ? ~reg_wdata : reg_wdata;
        nxt_st.tx_full = 1'b1;
      end else if (reg_addr == `UMPO_A_STAT) begin
        if (reg_wdata[`UMPO_B_BCOL]) begin
          nxt_st.bc_flag = 1'b0;
        end
      end else if (reg_addr == `UMPO_A_PDIR) begin
        nxt_st.pdir = reg_wdata;
      end else if (reg_addr == `UMPO_A_PDAT) begin
        nxt_st.pdat = reg_wdata;
      end
    end

    // Register reads
    if (reg_rd) begin
      if (reg_addr == `UMPO_A_MODE) begin
        nxt_st.rd_data = st_ff.mode;
      end else if (reg_addr == `UMPO_A_FLOW) begin
        nxt_st.rd_data = st_ff.flow;
      end else if (reg_addr == `UMPO_A_OPT) begin
        nxt_st.rd_data = st_ff.opt;
      end else if (reg_addr == `UMPO_A_DIV) begin
        nxt_st.rd_data = st_ff.div;
      end else if (reg_addr == `UMPO_A_RXBUF) begin
        nxt_st.rd_data = dinv_on ? ~st_ff.rx_buf : st_ff.rx_buf;
        nxt_st.rx_full = 1'b0;
      end else if (reg_addr == `UMPO_A_STAT) begin
        nxt_st.rd_data = stat_v;
      end else if (reg_addr == `UMPO_A_PDIR) begin
        nxt_st.rd_data = st_ff.pdir;
      end else if (reg_addr == `UMPO_A_PDAT) begin
        nxt_st.rd_data = st_ff.pdat;
      end
    end

    // Receiver
    case (st_ff.rx_st)
      RX_IDLE: begin
        if (rx_en && !rx_line) begin
          nxt_st.rx_ovs = 4'h0;
          nxt_st.rx_st  = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          nxt_st.rx_ovs = st_ff.rx_ovs + 4'h1;
          if (st_ff.rx_ovs == `UMPO_OVS_MID) begin
            nxt_st.rx_ovs = 4'h0;
            nxt_st.rx_bit = 3'h0;
            nxt_st.rx_st  = rx_line ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          nxt_st.rx_ovs = st_ff.rx_ovs + 4'h1;
          if (st_ff.rx_ovs == `UMPO_OVS_LAST) begin
            nxt_st.rx_sh  = {rx_line, st_ff.rx_sh[7:1]};
            nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
            if (st_ff.rx_bit == `UMPO_BIT_LAST) begin
              nxt_st.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          nxt_st.rx_ovs = st_ff.rx_ovs + 4'h1;
          if (st_ff.rx_ovs == `UMPO_OVS_LAST) begin
            nxt_st.rx_st = RX_IDLE;
            if (!sleep_on || st_ff.rx_sh[7]) begin
              nxt_st.rx_buf  = st_ff.rx_sh;
              nxt_st.rx_full = 1'b1;
              nxt_st.rx_req  = 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_st.rx_st = RX_IDLE;
      end
    endcase

    // Collision detection, set wins over clear
    if (bc_sample && bc_diff) begin
      nxt_st.bc_req  = 1'b1;
      nxt_st.bc_flag = 1'b1;
    end

    // Serial-out pin, high while idle, floats when open-drain high
    nxt_st.sout    = sout_lvl;
    nxt_st.sout_oe = tx_en & (open_drain ? ~sout_lvl : 1'b1);

    // Bit-clock pin
    if (ext_ok && st_ff.mode[`UMPO_B_CKSEL] && !st_ff.pdir[`UMPO_B_PBCLK]) begin
      nxt_st.bclk_oe = 1'b0;
      nxt_st.bclk_o  = 1'b0;
    end else begin
      nxt_st.bclk_oe = st_ff.pdir[`UMPO_B_PBCLK];
      nxt_st.bclk_o  = st_ff.pdat[`UMPO_B_PBCLK];
    end

    // Flow-control pin
    if (!st_ff.flow[`UMPO_B_FDIS] && st_ff.flow[`UMPO_B_FSEL]) begin
      nxt_st.flow_oe = 1'b1;
      nxt_st.flow_o  = ~rts_ready;
    end else begin
      nxt_st.flow_oe = st_ff.pdir[`UMPO_B_PFLOW];
      nxt_st.flow_o  = st_ff.pdat[`UMPO_B_PFLOW];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata           = st_ff.rd_data;
  assign serial_out_pin_o    = st_ff.sout;
  assign serial_out_pin_oe   = st_ff.sout_oe;
  assign bit_clock_pin_o     = st_ff.bclk_o;
  assign bit_clock_pin_oe    = st_ff.bclk_oe;
  assign flow_control_pin_o  = st_ff.flow_o;
  assign flow_control_pin_oe = st_ff.flow_oe;
  assign rx_req              = st_ff.rx_req;
  assign bc_req              = st_ff.bc_req;

  sequence s_tx_start;
    st_ff.tx_st == TX_IDLE ##1 st_ff.tx_st == TX_START;
  endsequence

  sequence s_rx_done;
    st_ff.rx_st == RX_STOP && tick && st_ff.rx_ovs == `UMPO_OVS_LAST;
  endsequence

  property p_bclk_port;
    @(posedge ref_clk) disable iff (sys_rst)
    !st_ff.mode[`UMPO_B_CKSEL] |=> bit_clock_pin_oe == $past(st_ff.pdir[`UMPO_B_PBCLK]);
  endproperty
  a_bclk_port: assert property (p_bclk_port) else $error("bit clock pin not a port");

  property p_bclk_in;
    @(posedge ref_clk) disable iff (sys_rst)
    ext_sel |=> !bit_clock_pin_oe;
  endproperty
  a_bclk_in: assert property (p_bclk_in) else $error("bit clock pin driven in ext mode");

  property p_ch2_int;
    @(posedge ref_clk) disable iff (sys_rst)
    is_ch2 |-> !ext_sel ##1 bit_clock_pin_oe == $past(st_ff.pdir[`UMPO_B_PBCLK]);
  endproperty
  a_ch2_int: assert property (p_ch2_int) else $error("channel 2 on external clock");

  property p_cts;
    @(posedge ref_clk) disable iff (sys_rst)
    s_tx_start |-> $past(cts_ok) && $past(st_ff.tx_full);
  endproperty
  a_cts: assert property (p_cts) else $error("frame started without clear to send");

  property p_rts;
    @(posedge ref_clk) disable iff (sys_rst)
    (!st_ff.flow[`UMPO_B_FDIS] && st_ff.flow[`UMPO_B_FSEL])
      |=> flow_control_pin_oe && (flow_control_pin_o == !$past(rts_ready));
  endproperty
  a_rts: assert property (p_rts) else $error("request to send level wrong");

  property p_flow_port;
    @(posedge ref_clk) disable iff (sys_rst)
    st_ff.flow[`UMPO_B_FDIS] |=> flow_control_pin_oe == $past(st_ff.pdir[`UMPO_B_PFLOW])
      && flow_control_pin_o == $past(st_ff.pdat[`UMPO_B_PFLOW]);
  endproperty
  a_flow_port: assert property (p_flow_port) else $error("flow pin not a port");

  property p_sleep_take;
    @(posedge ref_clk) disable iff (sys_rst)
    s_rx_done ##0 (!sleep_on || st_ff.rx_sh[7])
      |=> rx_req && st_ff.rx_buf == $past(st_ff.rx_sh);
  endproperty
  a_sleep_take: assert property (p_sleep_take) else $error("character not accepted");

  property p_sleep_drop;
    @(posedge ref_clk) disable iff (sys_rst)
    s_rx_done ##0 (sleep_on && !st_ff.rx_sh[7]) |=> !rx_req && $stable(st_ff.rx_buf);
  endproperty
  a_sleep_drop: assert property (p_sleep_drop) else $error("sleep character kept");

  property p_tx_inv;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `UMPO_A_TXBUF && dinv_on) |=> st_ff.txbuf == ~$past(reg_wdata);
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("transmit data not inverted");

  property p_rx_inv;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `UMPO_A_RXBUF && dinv_on) |=> reg_rdata == ~$past(st_ff.rx_buf);
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("receive data not inverted");

  property p_polarity;
    @(posedge ref_clk) disable iff (sys_rst)
    prev_on |=> serial_out_pin_o == $past(st_ff.tx_low);
  endproperty
  a_polarity: assert property (p_polarity) else $error("serial out not reversed");

  property p_bc;
    @(posedge ref_clk) disable iff (sys_rst)
    (bc_sample && bc_diff) |=> bc_req && st_ff.bc_flag;
  endproperty
  a_bc: assert property (p_bc) else $error("collision not reported");

  property p_bc_busy;
    @(posedge ref_clk) disable iff (sys_rst)
    bc_req |-> $past(tx_busy) && $past(is_ch2);
  endproperty
  a_bc_busy: assert property (p_bc_busy) else $error("collision outside a frame");

  property p_idle_high;
    @(posedge ref_clk) disable iff (sys_rst)
    (!st_ff.tx_low && tx_en && !open_drain && !prev_on) |=> serial_out_pin_o && serial_out_pin_oe;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial out not high");

  property p_frame_bits;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_ff.tx_st == TX_START |-> st_ff.tx_low) and (st_ff.tx_st == TX_STOP |-> !st_ff.tx_low);
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("start or stop level wrong");

endmodule

// ===== dv/umpo_peer.sv
`timescale 1ns/1ps

module umpo_peer #(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic drv;
  logic inv;
  logic echo;
  logic jam;

  initial begin
    drv  = 1'b1;
    inv  = 1'b0;
    echo = 1'b0;
    jam  = 1'b0;
  end

  // Idle mark level, reversed line, loopback or jammed line
  assign line_out = jam ? 1'b0 : (echo ? line_in : (drv ^ inv));

  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    drv <= 1'b1;
  endtask

  // Returns stop, data and start levels as one frame
  task automatic grab(input int n, output logic [9:0] f, output logic ok);
    ok = 1'b0;
    f  = '0;
    for (int k = 0; k < n && !ok; k++) begin
      @(posedge ref_clk);
      if ((line_in ^ inv) === 1'b0) begin
        ok = 1'b1;
      end
    end
    if (ok) begin
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      f[0] = line_in ^ inv;
      for (int i = 1; i < 10; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk);
        f[i] = line_in ^ inv;
      end
    end
  endtask
endmodule

// ===== dv/uart_mode_pins_and_options_test.sv
`timescale 1ns/1ps
`include "umpo_consts.svh"

module uart_mode_pins_and_options_test;
  logic       ref_clk;
  logic       sys_rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       sel;
  logic       bclk;
  logic [1:0][7:0] rdata;
  logic [1:0] so_o, so_oe, sin, bc_o, bc_oe, fl_i, fl_o, fl_oe, rxq, bcq;
  logic [9:0] fr;
  logic [7:0] d;
  logic       ok;
  int         cnt;
  int         fail_count;
  int         tests_run;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    umpo_top #(.CHANNEL(g ? 2'h2 : 2'h0)) umpo_top_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr & (sel == 1'(g))), .reg_rd(reg_rd & (sel == 1'(g))),
      .reg_rdata(rdata[g]), .serial_out_pin_o(so_o[g]), .serial_out_pin_oe(so_oe[g]),
      .serial_in_pin_i(sin[g]), .bit_clock_pin_i(bclk), .bit_clock_pin_o(bc_o[g]),
      .bit_clock_pin_oe(bc_oe[g]), .flow_control_pin_i(fl_i[g]),
      .flow_control_pin_o(fl_o[g]), .flow_control_pin_oe(fl_oe[g]),
      .rx_req(rxq[g]), .bc_req(bcq[g]));
    umpo_peer umpo_peer_inst (.ref_clk(ref_clk), .line_in(~so_oe[g] | so_o[g]),
      .line_out(sin[g]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rst();
    sys_rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata[sel];
    @(posedge ref_clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pulses(input logic coll, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if ((coll ? bcq[sel] : rxq[sel]) === 1'b1) begin
        c++;
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    sys_rst    = 1'b1;
    reg_addr   = 4'h0;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    sel        = 1'b0;
    fl_i       = 2'b00;
    bclk       = 1'b0;
    fail_count = 0;
    tests_run  = 0;
    rst();
    // Channel 0: pin functions, flow control, sleep reception
    wr(`UMPO_A_OPT, 8'h01);
    settle();
    check("sout idle", {so_oe[0], so_o[0]}, 2'b11);
    @(posedge ref_clk);
    wr(`UMPO_A_FLOW, 8'h20);
    settle();
    check("sout open drain", so_oe[0], 1'b0);
    @(posedge ref_clk);
    wr(`UMPO_A_MODE, 8'h00);
    wr(`UMPO_A_PDIR, 8'h06);
    wr(`UMPO_A_PDAT, 8'h06);
    wr(`UMPO_A_FLOW, 8'h10);
    settle();
    check("port pins high", {bc_oe[0], bc_o[0], fl_oe[0], fl_o[0]}, 4'hF);
    @(posedge ref_clk);
    wr(`UMPO_A_PDAT, 8'h00);
    settle();
    check("port pins low", {bc_oe[0], bc_o[0], fl_oe[0], fl_o[0]}, 4'hA);
    @(posedge ref_clk);
    wr(`UMPO_A_MODE, 8'h08);
    wr(`UMPO_A_PDIR, 8'h04);
    settle();
    check("bit clock input", bc_oe[0], 1'b0);
    @(posedge ref_clk);
    wr(`UMPO_A_TXBUF, 8'h01);
    repeat (40) @(posedge ref_clk);
    settle();
    check("ext clock hold", so_o[0], 1'b0);
    @(posedge ref_clk);
    repeat (16) begin
      bclk <= 1'b1;
      @(posedge ref_clk);
      bclk <= 1'b0;
      @(posedge ref_clk);
    end
    settle();
    check("ext clock bit", so_o[0], 1'b1);
    @(posedge ref_clk);
    wr(`UMPO_A_MODE, 8'h00);
    repeat (200) @(posedge ref_clk);
    wr(`UMPO_A_DIV, 8'h01);
    wr(`UMPO_A_TXBUF, 8'h01);
    repeat (20) @(posedge ref_clk);
    settle();
    check("div start bit", so_o[0], 1'b0);
    @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    settle();
    check("div first bit", so_o[0], 1'b1);
    @(posedge ref_clk);
    wr(`UMPO_A_DIV, 8'h00);
    repeat (200) @(posedge ref_clk);
    wr(`UMPO_A_PDIR, 8'h00);
    fl_i[0] <= 1'b1;
    wr(`UMPO_A_FLOW, 8'h00);
    wr(`UMPO_A_TXBUF, 8'h3C);
    g_ch[0].umpo_peer_inst.grab(64, fr, ok);
    check("cts hold", ok, 1'b0);
    fl_i[0] <= 1'b0;
    g_ch[0].umpo_peer_inst.grab(4000, fr, ok);
    check("cts frame", fr, 10'h278);
    wr(`UMPO_A_OPT, 8'h05);
    wr(`UMPO_A_FLOW, 8'h04);
    wr(`UMPO_A_MODE, 8'h80);
    settle();
    check("rts ready", {fl_oe[0], fl_o[0]}, 2'b10);
    @(posedge ref_clk);
    fork
      g_ch[0].umpo_peer_inst.send(8'h35);
      pulses(1'b0, 200, cnt);
    join
    check("sleep drop req", 10'(cnt), 10'h000);
    rd(`UMPO_A_STAT, d);
    check("sleep drop full", d[2], 1'b0);
    fork
      g_ch[0].umpo_peer_inst.send(8'hB5);
      pulses(1'b0, 200, cnt);
    join
    check("sleep take req", 10'(cnt), 10'h001);
    settle();
    check("rts busy", {fl_oe[0], fl_o[0]}, 2'b11);
    @(posedge ref_clk);
    rd(`UMPO_A_RXBUF, d);
    check("sleep data", d, 8'hB5);
    $display("test channel0 done");
    rst();
    // Channel 2: data inversion, polarity reverse, collision
    sel <= 1'b1;
    wr(`UMPO_A_MODE, 8'h00);
    wr(`UMPO_A_OPT, 8'h45);
    wr(`UMPO_A_TXBUF, 8'h0F);
    g_ch[1].umpo_peer_inst.grab(4000, fr, ok);
    check("inverted frame", fr, 10'h3E0);
    fork
      g_ch[1].umpo_peer_inst.send(8'h3C);
      pulses(1'b0, 200, cnt);
    join
    check("inverted rx req", 10'(cnt), 10'h001);
    rd(`UMPO_A_RXBUF, d);
    check("inverted rx data", d, 8'hC3);
    wr(`UMPO_A_OPT, 8'h25);
    g_ch[1].umpo_peer_inst.inv <= 1'b1;
    settle();
    check("reversed idle", so_o[1], 1'b0);
    @(posedge ref_clk);
    wr(`UMPO_A_TXBUF, 8'h5A);
    g_ch[1].umpo_peer_inst.grab(4000, fr, ok);
    check("reversed frame", fr, 10'h2B4);
    fork
      g_ch[1].umpo_peer_inst.send(8'h81);
      pulses(1'b0, 200, cnt);
    join
    check("reversed rx req", 10'(cnt), 10'h001);
    rd(`UMPO_A_RXBUF, d);
    check("reversed rx data", d, 8'h81);
    wr(`UMPO_A_OPT, 8'h05);
    g_ch[1].umpo_peer_inst.inv  <= 1'b0;
    g_ch[1].umpo_peer_inst.echo <= 1'b1;
    wr(`UMPO_A_STAT, 8'h08);
    wr(`UMPO_A_TXBUF, 8'hFF);
    pulses(1'b1, 200, cnt);
    check("echo no collision", 10'(cnt), 10'h000);
    g_ch[1].umpo_peer_inst.echo <= 1'b0;
    g_ch[1].umpo_peer_inst.jam  <= 1'b1;
    pulses(1'b1, 200, cnt);
    check("idle no collision", 10'(cnt), 10'h000);
    rd(`UMPO_A_STAT, d);
    check("collision flag clear", d[3], 1'b0);
    wr(`UMPO_A_TXBUF, 8'hFF);
    pulses(1'b1, 200, cnt);
    check("jam collision", 10'(cnt != 0), 10'h001);
    g_ch[1].umpo_peer_inst.jam <= 1'b0;
    rd(`UMPO_A_STAT, d);
    check("collision flag", d[3], 1'b1);
    $display("test channel2 done");
    results();
  end
endmodule
